/* hdl/sps_top.v */
// standby power shutdown timer with axi4-lite register access
`timescale 1ns/10ps
`default_nettype none
`include "sps_regs.vh"
module sps_top #(
  parameter TICK_CYCLES = `SPS_TICK_CYCLES,  // cycles per 1 ms timer tick
  parameter OFF_TICKS   = `SPS_OFF_MS,       // relay off time of the reset pulse
  parameter SETTLE_TICKS = `SPS_SETTLE_MS    // mains settle time after energise
) (
  input  wire        clk,
  input  wire        rst,
  // axi4-lite slave
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // drive side
  input  wire        drive_field_enable_input,   // pin, high = enabled
  input  wire        mains_present,              // pin, three-phase sensed
  input  wire        drive_at_rest,              // from drive logic
  input  wire        fault_reset,                // one-cycle pulse from drive logic
  output reg         power_contactor_relay_output,
  output reg         fan_enable,
  output reg         field_current_zero,
  output reg         line_resync,                // one-cycle pulse
  output reg         supply_fault
);

  // one-hot sequencer states
  // the keep state covers a timeout without the standby option: mains stays
  // on and only the field is forced to zero until the idle spell ends
  localparam [3:0] ST_OFF   = 4'b0001;  // reset pulse, relay dropped
  localparam [3:0] ST_RUN   = 4'b0010;  // relay energised, normal
  localparam [3:0] ST_SHUT  = 4'b0100;  // timed out, relay dropped
  localparam [3:0] ST_KEEP  = 4'b1000;  // timed out, option off: relay kept

  localparam DW = `SPS_DELAY_W;

  // register file
  // only the option and the delay are writable; status is read live
  reg [3:0]    relay_option;   // multi-purpose relay option code
  reg [DW-1:0] delay_ticks;    // shutdown delay, 0 disables timeout
  reg [15:0]   fault_code;     // last declared fault code

  // pin synchronisers, first stage read only by second
  reg en_meta;
  reg en_sync;
  reg mains_meta;
  reg mains_sync;

  // sequencer
  // seq_cnt serves both the reset pulse length and the settle time
  reg [3:0]    state;
  reg [31:0]   tick_div;       // prescaler toward one tick
  reg          tick;           // one-cycle enable per ms
  reg [DW-1:0] idle_cnt;       // elapsed idle ticks
  reg [15:0]   seq_cnt;        // off pulse / settle ticks
  reg          idle_prev;      // idle condition one cycle ago
  reg          armed;          // mains loss detection enabled

  // axi bookkeeping
  // address and data may arrive in either order; each is held until both are in
  reg          aw_held;
  reg          w_held;
  reg [3:0]    aw_addr;
  reg [31:0]   w_data;
  reg [3:0]    w_strb;

  // idle means at rest with the enable pin released; only the synchronised copy
  // is used so a pin edge near the clock cannot split the decision
  wire standby_sel = (relay_option == `SPS_OPT_STANDBY);
  wire idle        = drive_at_rest & ~en_sync;
  wire idle_start  = idle & ~idle_prev;
  wire timeout_hit = (delay_ticks != {DW{1'b0}}) && (idle_cnt >= delay_ticks);

  // apply byte enables to one register word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  // address decode shared by read and write paths
  function mapped;
    input [3:0] a;
    begin
      mapped = (a == `SPS_CTRL_OFS) || (a == `SPS_DELAY_OFS) ||
               (a == `SPS_STATUS_OFS) || (a == `SPS_FAULT_OFS);
    end
  endfunction

  // byte-lane merges of the writable words; the slice is taken from these nets
  // because a function result cannot be part-selected where it is called
  wire [31:0] ctrl_merged  = merge({28'h0000000, relay_option}, w_data, w_strb);
  wire [31:0] delay_merged = merge({16'h0000, delay_ticks}, w_data, w_strb);

  // two-flop synchronisers for the enable and mains pins
  // both pins come from field wiring and are asynchronous to this clock
  always @(posedge clk) begin
    if (rst) begin
      en_meta    <= 1'b0;
      en_sync    <= 1'b0;
      mains_meta <= 1'b0;
      mains_sync <= 1'b0;
    end else begin
      en_meta    <= drive_field_enable_input;
      en_sync    <= en_meta;
      mains_meta <= mains_present;
      mains_sync <= mains_meta;
    end
  end

  // tick divider; restarted with each idle period so the first tick is a full one
  // the cost: the reset pulse and the settle time may see one stretched tick
  // when an idle spell starts while they run
  always @(posedge clk) begin
    if (rst || idle_start) begin
      tick_div <= 32'h0000_0000;
      tick     <= 1'b0;
    end else if (tick_div == TICK_CYCLES - 1) begin
      tick_div <= 32'h0000_0000;
      tick     <= 1'b1;
    end else begin
      tick_div <= tick_div + 32'h0000_0001;
      tick     <= 1'b0;
    end
  end

  // idle timer; any break in the idle condition clears the count, so a short
  // spell never carries over into the next one; the count stops at a nonzero delay
  always @(posedge clk) begin
    if (rst) begin
      idle_cnt  <= {DW{1'b0}};
      idle_prev <= 1'b0;
    end else begin
      idle_prev <= idle;
      if (!idle) begin
        idle_cnt <= {DW{1'b0}};
      end else if (idle_start) begin
        idle_cnt <= {DW{1'b0}};
      end else if (tick && !timeout_hit) begin
        idle_cnt <= idle_cnt + {{(DW-1){1'b0}}, 1'b1};
      end
    end
  end

  // sequencer: reset pulse, run, shutdown
  // fault reset is taken ahead of every state so a pulse in mid-shutdown
  // still gives the full off-then-on sequence
  always @(posedge clk) begin
    if (rst) begin
      state   <= ST_OFF;
      seq_cnt <= 16'h0000;
      armed   <= 1'b0;
    end else if (fault_reset) begin
      // fault reset repeats the off-then-on pulse whatever the delay
      state   <= ST_OFF;
      seq_cnt <= 16'h0000;
      armed   <= 1'b0;
    end else begin
      case (state)
        ST_OFF: begin
          if (tick) begin
            if (seq_cnt == OFF_TICKS - 1) begin
              state   <= ST_RUN;
              seq_cnt <= 16'h0000;
            end else begin
              seq_cnt <= seq_cnt + 16'h0001;
            end
          end
        end
        ST_RUN: begin
          // arm loss detection once mains has had time to settle
          if (!armed && tick) begin
            if (seq_cnt == SETTLE_TICKS - 1) begin
              armed <= 1'b1;
            end else begin
              seq_cnt <= seq_cnt + 16'h0001;
            end
          end
          if (timeout_hit) begin
            state <= standby_sel ? ST_SHUT : ST_KEEP;
            armed <= 1'b0;
          end
        end
        ST_SHUT: begin
          // wake on the synchronised enable only
          if (en_sync) begin
            state   <= ST_RUN;
            seq_cnt <= 16'h0000;
          end
        end
        ST_KEEP: begin
          // relay kept on, drive carries on with field forced to zero
          if (!idle) begin
            state   <= ST_RUN;
            seq_cnt <= 16'h0000;
          end
        end
        default: begin
          state <= ST_OFF;
        end
      endcase
    end
  end

  // drive outputs, all registered
  always @(posedge clk) begin
    if (rst) begin
      power_contactor_relay_output <= 1'b0;
      fan_enable                   <= 1'b0;
      field_current_zero           <= 1'b1;
      line_resync                  <= 1'b0;
    end else begin
      power_contactor_relay_output <= (state == ST_RUN) || (state == ST_KEEP);
      // fans follow the relay: with mains off they would have nothing to run on
      fan_enable                   <= (state == ST_RUN) || (state == ST_KEEP);
      field_current_zero           <= (state != ST_RUN);
      // resync on the very edge the relay re-energises, after a reset pulse or a shutdown
      line_resync                  <= (state == ST_RUN) && !power_contactor_relay_output;
    end
  end

  // supply loss that was not commanded raises the fault; external logic
  // must only cut power through the relay, so any loss here is a fault
  // the check is armed only in the run state after the settle time, so the
  // contactor's own pick-up delay is never mistaken for a loss
  always @(posedge clk) begin
    if (rst) begin
      supply_fault <= 1'b0;
      fault_code   <= 16'h0000;
    end else if (armed && state == ST_RUN && !mains_sync) begin
      supply_fault <= 1'b1;
      fault_code   <= `SPS_FAULT_CODE;
    end else if (fault_reset) begin
      supply_fault <= 1'b0;
    end
  end

  // axi write: address and data taken in either order, one at a time
  // writes to the status and fault words are answered and ignored
  always @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SPS_RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 4'h0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      relay_option  <= `SPS_CTRL_RST;
      delay_ticks   <= `SPS_DELAY_RST;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid && !aw_held && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr) ? `SPS_RESP_OKAY : `SPS_RESP_SLVERR;
        if (aw_addr == `SPS_CTRL_OFS) begin
          relay_option <= ctrl_merged[`SPS_OPT_MSB:`SPS_OPT_LSB];
        end
        if (aw_addr == `SPS_DELAY_OFS) begin
          delay_ticks <= delay_merged[DW-1:0];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi read: one cycle from address taken to data valid
  // rdata holds until rready, so a slow master still sees the word it asked for
  always @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SPS_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mapped(s_axi_araddr) ? `SPS_RESP_OKAY : `SPS_RESP_SLVERR;
        case (s_axi_araddr)
          `SPS_CTRL_OFS:   s_axi_rdata <= {28'h0000000, relay_option};
          `SPS_DELAY_OFS:  s_axi_rdata <= {16'h0000, delay_ticks};
          `SPS_STATUS_OFS: s_axi_rdata <= {27'h0000000, en_sync, mains_sync,
                                           supply_fault, field_current_zero,
                                           power_contactor_relay_output};
          `SPS_FAULT_OFS:  s_axi_rdata <= {16'h0000, fault_code};
          default:         s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_arvalid) begin
        // hold off new address until the previous data has gone
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

/* hdl/sps_regs.vh */
// register map, field positions, reset values and timing counts of the standby shutdown timer
// Notes on behaviour
// - shutdown only with standby relay option selected
// - timer held cleared while drive enabled
// - count at rest and disabled; expiry drops relay
// - zero delay disables timeout, relay stays on
// - enable after shutdown re-energises, resyncs, restarts fans
// - field current zero while power switched off
// - power-up and fault reset: relay off then on
// - off-then-on sequence runs with zero delay too
// - mains kept on after timeout: run, field zero
// - unexpected supply loss declares supply fault code; checked only in run after the settle time
`ifndef SPS_REGS_VH
`define SPS_REGS_VH
// byte offsets
`define SPS_CTRL_OFS      4'h0
`define SPS_DELAY_OFS     4'h4
`define SPS_STATUS_OFS    4'h8
`define SPS_FAULT_OFS     4'hc
// control fields
`define SPS_OPT_LSB       0
`define SPS_OPT_MSB       3
`define SPS_OPT_STANDBY   4'h5
`define SPS_CTRL_RST      4'h0
// delay register, units of one timer tick
`define SPS_DELAY_W       16
`define SPS_DELAY_RST     16'h0000
// status bit positions
`define SPS_ST_RELAY      0
`define SPS_ST_TIMEOUT    1
`define SPS_ST_FAULT      2
`define SPS_ST_MAINS      3
`define SPS_ST_ENABLE     4
// supply-loss fault code, 406 decimal
`define SPS_FAULT_CODE    16'h0196
// timing: clock 10 ns, tick 1 ms, off pulse 500 ms, mains settle 200 ms
`define SPS_CLK_NS        10
`define SPS_TICK_NS       1000000
`define SPS_TICK_CYCLES   (`SPS_TICK_NS / `SPS_CLK_NS)
`define SPS_OFF_MS        500
`define SPS_SETTLE_MS     200
// axi responses
`define SPS_RESP_OKAY     2'b00
`define SPS_RESP_SLVERR   2'b10
`endif

/* verification/sps_contactor.sv */
// partner model: pilot relay, mains contactor and supply sensing
`timescale 1ns/10ps
`default_nettype none
module sps_contactor (
  input  wire logic clk,
  input  wire logic coil,   // relay output of the block
  input  wire logic trip,   // bench-commanded loss of mains
  output var  logic mains
);
  logic [1:0] lag = 2'b00;  // contactor pick and drop delay
  // power follows the coil only; trip fakes an uncommanded loss
  always @(posedge clk) begin
    lag <= {lag[0], coil};
    mains <= lag[1] & ~trip;
  end
endmodule
`default_nettype wire

/* verification/sps_top_sva.sv */
// checker of the standby shutdown timer ports
`timescale 1ns/10ps
`default_nettype none
module sps_top_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic drive_field_enable_input,
  input wire logic mains_present,
  input wire logic fault_reset,
  input wire logic power_contactor_relay_output,
  input wire logic fan_enable,
  input wire logic field_current_zero,
  input wire logic line_resync,
  input wire logic supply_fault
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // fans must never run without mains
  chk_fan_follow: assert property (fan_enable == power_contactor_relay_output)
    else $error("fans differ from relay");
  chk_field_off: assert property (!power_contactor_relay_output |-> field_current_zero)
    else $error("field on with mains off");
  // the state changes on the edge that samples the pulse, the relay one edge later
  chk_reset_drop: assert property (fault_reset |-> ##2 !power_contactor_relay_output)
    else $error("relay kept after fault reset");
  chk_resync_edge: assert property ($rose(power_contactor_relay_output) |-> line_resync)
    else $error("no resync on energise");
  chk_resync_pulse: assert property (line_resync |=> !line_resync)
    else $error("resync longer than a cycle");
  // a drop follows a fault reset two samples back, or a timeout that needs the
  // enable pin low four samples back (two sync flops, state, output)
  property relay_drop_cause;
    $fell(power_contactor_relay_output) |-> $past(fault_reset, 2) || !$past(drive_field_enable_input, 4);
  endproperty
  chk_enabled_hold: assert property (relay_drop_cause)
    else $error("relay dropped while enabled");
  chk_fault_hold: assert property ($fell(supply_fault) |-> $past(fault_reset))
    else $error("supply fault cleared alone");
  chk_mains_ok: assert property (mains_present [*6] |-> !$rose(supply_fault))
    else $error("supply fault with mains present");
  chk_read_answer: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  cover property ($fell(power_contactor_relay_output) && !$past(fault_reset, 2));
  cover property ($rose(supply_fault));
  cover property ($rose(line_resync));
endmodule
bind sps_top sps_top_sva u_sva (.*);
`default_nettype wire

/* verification/standby_power_shutdown_timer_bench.sv */
// testbench of the standby power shutdown timer
`timescale 1ns/10ps
`default_nettype none
`include "sps_regs.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module standby_power_shutdown_timer_bench;
  logic clk = 1'b0, rst = 1'b1;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic en = 1'b1, at_rest = 1'b1, frst = 1'b0, trip = 1'b0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic relay, fan, fcz, resync, supply_fault, mains;
  int checks = 0, err_total = 0, cyc = 0, n_sync = 0, n0;
  always #5 clk = ~clk;
  // short ticks keep the run brief: 4 cycles a tick
  // a settle of 3 ticks outlasts the contactor lag plus the two sync flops
  sps_top #(.TICK_CYCLES(4), .OFF_TICKS(3), .SETTLE_TICKS(3)) dut (.clk, .rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .drive_field_enable_input(en),
    .mains_present(mains), .drive_at_rest(at_rest), .fault_reset(frst),
    .power_contactor_relay_output(relay), .fan_enable(fan), .field_current_zero(fcz),
    .line_resync(resync), .supply_fault);
  sps_contactor u_far (.clk, .coil(relay), .trip, .mains);
  // count resync pulses and cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (resync === 1'b1) n_sync++;
    if (cyc == 5000) begin
      err_total++;
      end_of_test();
    end
  end
  task end_of_test;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // each channel released at its own handshake
    do begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, `SPS_RESP_OKAY)
  endtask
  task rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, ed)
    `CHK(s_axi_rresp, er)
  endtask
  task wt(input logic v);
    while (relay !== v) @(posedge clk);
  endtask
  task pulse_reset;
    @(posedge clk);
    frst <= 1'b1;
    @(posedge clk);
    frst <= 1'b0;
    @(posedge clk);
    // relay drops one edge after the state, so look one edge later
    @(posedge clk);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK(relay, 1'b0)
    wt(1'b1);
    rd(`SPS_CTRL_OFS, 32'h0, `SPS_RESP_OKAY);
    rd(`SPS_DELAY_OFS, 32'h0, `SPS_RESP_OKAY);
    rd(4'h2, 32'h0, `SPS_RESP_SLVERR);
    en <= 1'b0;
    repeat (60) @(posedge clk);
    `CHK({relay, fcz}, 2'b10)
    wr(`SPS_DELAY_OFS, 32'h3);
    repeat (40) @(posedge clk);
    `CHK({relay, fcz}, 2'b11)
    en <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(fcz, 1'b0)
    wr(`SPS_CTRL_OFS, {28'h0, `SPS_OPT_STANDBY});
    repeat (40) @(posedge clk);
    `CHK(relay, 1'b1)
    // an idle spell cut short must not carry its count over
    en <= 1'b0;
    repeat (8) @(posedge clk);
    en <= 1'b1;
    repeat (4) @(posedge clk);
    en <= 1'b0;
    repeat (16) @(posedge clk);
    `CHK(relay, 1'b1)
    wt(1'b0);
    repeat (8) @(posedge clk);
    `CHK({fan, fcz, supply_fault}, 3'b010)
    rd(`SPS_STATUS_OFS, 32'h2, `SPS_RESP_OKAY);
    n0 = n_sync;
    en <= 1'b1;
    wt(1'b1);
    @(posedge clk);
    `CHK({fan, n_sync}, {1'b1, n0 + 32'd1})
    wr(`SPS_DELAY_OFS, 32'h0);
    pulse_reset();
    `CHK(relay, 1'b0)
    wt(1'b1);
    repeat (20) @(posedge clk);
    trip <= 1'b1;
    repeat (12) @(posedge clk);
    `CHK(supply_fault, 1'b1)
    rd(`SPS_FAULT_OFS, {16'h0, `SPS_FAULT_CODE}, `SPS_RESP_OKAY);
    trip <= 1'b0;
    // let mains pass the sync flops first, a loss seen with the reset would win
    repeat (4) @(posedge clk);
    pulse_reset();
    `CHK(supply_fault, 1'b0)
    end_of_test();
  end
endmodule
`default_nettype wire
